// file: rtl/fpx_pkg.sv
// package: register layout, instruction classes and phase states
package fpx_pkg;
  localparam int unsigned csr_width = 32;
  localparam int unsigned addr_width = 4;
  localparam logic [addr_width-1:0] csr_offset = 4'h0;
  localparam logic [addr_width-1:0] sys_ctrl_offset = 4'h4;
  localparam logic [addr_width-1:0] status_offset = 4'h8;
  localparam int unsigned invalid_flag_bit = 0;
  localparam int unsigned denormal_flag_bit = 1;
  localparam int unsigned divzero_flag_bit = 2;
  localparam int unsigned overflow_flag_bit = 3;
  localparam int unsigned underflow_flag_bit = 4;
  localparam int unsigned inexact_flag_bit = 5;
  localparam int unsigned daz_bit = 6;
  localparam int unsigned invalid_mask_bit = 7;
  localparam int unsigned denormal_mask_bit = 8;
  localparam int unsigned divzero_mask_bit = 9;
  localparam int unsigned overflow_mask_bit = 10;
  localparam int unsigned underflow_mask_bit = 11;
  localparam int unsigned inexact_mask_bit = 12;
  localparam int unsigned ftz_bit = 15;
  localparam int unsigned os_simd_trap_support_bit = 10;
  localparam int unsigned flag_lo = 0;
  localparam int unsigned mask_lo = 7;
  localparam logic [csr_width-1:0] csr_reset = 32'h0000_1f80;
  localparam logic [csr_width-1:0] csr_write_mask = 32'h0000_9fff;
  localparam logic [csr_width-1:0] sys_ctrl_reset = 32'h0000_0000;
  typedef enum logic [3:0] {
    op_arith = 4'h0,
    op_ordered_compare = 4'h1,
    op_compare_signaling = 4'h2,
    op_compare_quiet = 4'h3,
    op_convert_int = 4'h4,
    op_recip_approx = 4'h5,
    op_divide_double = 4'h6,
    op_other = 4'h7
  } op_class_type;
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_pre = 3'h1,
    st_pre_trap = 3'h2,
    st_post = 3'h3,
    st_post_trap = 3'h4,
    st_done = 3'h5
  } phase_type;
endpackage

// file: rtl/fpx_elem_if.sv
// interface: per-element condition bits from the checker array
`timescale 1ns/1ps
`default_nettype none
interface fpx_elem_if #(parameter int unsigned lanes = 4);
  logic [lanes-1:0] invalid;
  logic [lanes-1:0] denormal;
  logic [lanes-1:0] divzero;
  logic [lanes-1:0] overflow;
  logic [lanes-1:0] underflow;
  logic [lanes-1:0] inexact;
  logic [lanes-1:0] flush;
  logic [lanes-1:0] daz_zero;
  modport checker_side (output invalid, denormal, divzero, overflow, underflow, inexact,
    output flush, daz_zero);
  modport unit_side (input invalid, denormal, divzero, overflow, underflow, inexact,
    input flush, daz_zero);
endinterface
`default_nettype wire

// file: rtl/fpx_lane_check.sv
// lane checker: per-element condition detection
`timescale 1ns/1ps
`default_nettype none
module fpx_lane_check
  import fpx_pkg::*;
#(
  parameter int unsigned lanes = 4
) (
  // instruction
  input wire op_class_type op_class,
  input wire logic daz_en,
  input wire logic ftz_en,
  input wire logic underflow_masked,
  // per-lane operand classification
  input wire logic [lanes-1:0] src_snan,
  input wire logic [lanes-1:0] src_qnan,
  input wire logic [lanes-1:0] src_denormal,
  input wire logic [lanes-1:0] invalid_arith,
  input wire logic [lanes-1:0] dividend_finite_nonzero,
  input wire logic [lanes-1:0] divisor_zero,
  // per-lane rounded result classification
  input wire logic [lanes-1:0] res_too_big,
  input wire logic [lanes-1:0] res_tiny,
  input wire logic [lanes-1:0] res_inexact,
  // element flags
  fpx_elem_if.checker_side elem
);
  // ****************
  // shared decode
  // ****************
  wire logic qnan_signals;
  wire logic no_denormal;
  wire logic post_capable;
  assign qnan_signals = (op_class == op_ordered_compare) || (op_class == op_compare_signaling);
  assign no_denormal = (op_class == op_convert_int) || (op_class == op_recip_approx);
  assign post_capable = (op_class == op_arith) || (op_class == op_divide_double);

  // ****************
  // per lane
  // ****************
  for (genvar i = 0; i < lanes; i++) begin : g_lane
    wire logic daz_hit;
    assign daz_hit = daz_en && src_denormal[i] && !no_denormal;
    assign elem.invalid[i] = src_snan[i] || invalid_arith[i] || (qnan_signals && src_qnan[i]);
    assign elem.denormal[i] = src_denormal[i] && !no_denormal && !daz_en;
    assign elem.daz_zero[i] = daz_hit;
    assign elem.divzero[i] = (op_class == op_divide_double) && dividend_finite_nonzero[i]
      && divisor_zero[i];
    assign elem.overflow[i] = post_capable && res_too_big[i];
    assign elem.underflow[i] = post_capable && res_tiny[i]
      && (!underflow_masked || res_inexact[i] || (ftz_en && underflow_masked));
    assign elem.inexact[i] = post_capable && (res_inexact[i] || (ftz_en && underflow_masked
      && res_tiny[i]));
    assign elem.flush[i] = post_capable && ftz_en && underflow_masked && res_tiny[i];
  end
endmodule
`default_nettype wire

// file: rtl/simd_fp_exception_unit.sv
// top: SIMD floating-point exception detection, flagging and trap sequencing
//
// How it works
// - unmasked invalid traps to software, operands left untouched
// - quiet NaN raises invalid only for ordered and signaling compares
// - invalid, divide-by-zero, overflow ignore flush-to-zero
// - invalid flag bit 0, mask bit 7
// - denormal source raises denormal unless denormals-are-zero is set; flag bit 1, mask bit 8
// - conversions and reciprocal approximations never raise denormal
// - denormals-are-zero bit 6 turns denormal sources into signed zero
// - double divide of finite nonzero by zero; flag bit 2, mask 9
// - rounded result above largest finite is overflow; flag 3, mask 10
// - unmasked: tiny reports underflow; masked: tiny and inexact, or tiny with flush-to-zero; flag 4, mask 11
// - flush-to-zero bit 15 with masked underflow writes signed zero
// - unrepresentable result raises inexact; mask bit 12, flag bit 5
// - flush-to-zero still reports inexact
// - pre-computation conditions handled before post-computation ones
// - one instruction may trap twice, once per phase
// - all masked: write masked results, no trap
// - masked underflow without inexact leaves underflow flag clear unless flush-to-zero bit 15 is set
// - per-element flags ORed per condition into status
// - unmasked pre conditions: set flags, keep operands, trap; else go post
// - support bit 10 selects simd trap or invalid-opcode trap
// - handler return resumes same instruction at post checking
// - post phase ORs, flags, keeps operands, traps, completes after return
// - masked results held until unmasked post handling finishes
// - masked invalid returns default per operation
`timescale 1ns/1ps
`default_nettype none
module simd_fp_exception_unit
  import fpx_pkg::*;
#(
  parameter int unsigned lanes = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [addr_width-1:0] reg_addr,
  input wire logic [csr_width-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [csr_width-1:0] reg_rdata,
  // instruction from datapath
  input wire logic instr_valid,
  input wire op_class_type op_class,
  input wire logic [lanes-1:0] src_snan,
  input wire logic [lanes-1:0] src_qnan,
  input wire logic [lanes-1:0] src_denormal,
  input wire logic [lanes-1:0] invalid_arith,
  input wire logic [lanes-1:0] dividend_finite_nonzero,
  input wire logic [lanes-1:0] divisor_zero,
  input wire logic [lanes-1:0] res_too_big,
  input wire logic [lanes-1:0] res_tiny,
  input wire logic [lanes-1:0] res_inexact,
  // controls to datapath
  output logic instr_busy,
  output logic [lanes-1:0] daz_zero_lane,
  output logic compute_go,
  output logic [lanes-1:0] flush_lane,
  output logic [lanes-1:0] masked_default_lane,
  output logic result_write,
  output logic instr_done,
  // trap dispatch
  output logic simd_fp_trap,
  output logic invalid_opcode_trap,
  output logic trap_post_phase,
  input wire logic handler_return
);
  // ****************
  // element checks
  // ****************
  fpx_elem_if #(.lanes(lanes)) elem ();
  logic [csr_width-1:0] csr_ff;
  logic [csr_width-1:0] sys_ctrl_ff;
  phase_type state_ff;
  phase_type nxt_state;
  op_class_type op_ff;

  fpx_lane_check #(.lanes(lanes)) u_check (
    .op_class(op_ff),
    .daz_en(csr_ff[daz_bit]),
    .ftz_en(csr_ff[ftz_bit]),
    .underflow_masked(csr_ff[underflow_mask_bit]),
    .src_snan(src_snan),
    .src_qnan(src_qnan),
    .src_denormal(src_denormal),
    .invalid_arith(invalid_arith),
    .dividend_finite_nonzero(dividend_finite_nonzero),
    .divisor_zero(divisor_zero),
    .res_too_big(res_too_big),
    .res_tiny(res_tiny),
    .res_inexact(res_inexact),
    .elem(elem.checker_side)
  );

  // ****************
  // reductions and masking
  // ****************
  wire logic any_invalid;
  wire logic any_denormal;
  wire logic any_divzero;
  wire logic any_overflow;
  wire logic any_underflow;
  wire logic any_inexact;
  wire logic [5:0] pre_hit;
  wire logic [5:0] post_hit;
  wire logic [5:0] masks;
  wire logic pre_unmasked;
  wire logic post_unmasked;
  wire logic os_support;
  wire logic in_pre;
  wire logic in_post;
  assign any_invalid = |elem.invalid;
  assign any_denormal = |elem.denormal;
  assign any_divzero = |elem.divzero;
  assign any_overflow = |elem.overflow;
  assign any_underflow = |elem.underflow;
  assign any_inexact = |elem.inexact;
  assign pre_hit = {3'h0, any_divzero, any_denormal, any_invalid};
  assign post_hit = {any_inexact, any_underflow, any_overflow, 3'h0};
  assign masks = csr_ff[inexact_mask_bit:invalid_mask_bit];
  assign pre_unmasked = |(pre_hit & ~masks);
  assign post_unmasked = |(post_hit & ~masks);
  assign os_support = sys_ctrl_ff[os_simd_trap_support_bit];
  assign in_pre = (state_ff == st_pre);
  assign in_post = (state_ff == st_post);

  // ****************
  // phase sequencer
  // ****************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_idle: begin
        if (instr_valid) begin
          nxt_state = st_pre;
        end
      end
      st_pre: begin
        if (pre_unmasked) begin
          nxt_state = st_pre_trap;
        end else begin
          nxt_state = st_post;
        end
      end
      st_pre_trap: begin
        if (handler_return) begin
          nxt_state = st_post;
        end
      end
      st_post: begin
        if (post_unmasked) begin
          nxt_state = st_post_trap;
        end else begin
          nxt_state = st_done;
        end
      end
      st_post_trap: begin
        if (handler_return) begin
          nxt_state = st_done;
        end
      end
      st_done: begin
        nxt_state = st_idle;
      end
      default: begin
        nxt_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_ff <= op_other;
    end else if (state_ff == st_idle && instr_valid) begin
      op_ff <= op_class;
    end
  end

  // ****************
  // trap outputs
  // ****************
  wire logic trap_fire;
  assign trap_fire = (in_pre && pre_unmasked) || (in_post && post_unmasked);
  assign simd_fp_trap = trap_fire && os_support;
  assign invalid_opcode_trap = trap_fire && !os_support;
  assign trap_post_phase = in_post;
  assign instr_busy = (state_ff != st_idle);
  assign daz_zero_lane = elem.daz_zero;
  // operands stay untouched while a pre trap is pending
  assign compute_go = in_post;
  assign flush_lane = elem.flush;
  assign result_write = (state_ff == st_done);
  assign masked_default_lane = elem.invalid & {lanes{csr_ff[invalid_mask_bit]}};
  assign instr_done = (state_ff == st_done);

  // ****************
  // registers
  // ****************
  wire logic csr_sel;
  wire logic sys_sel;
  wire logic [5:0] set_pre;
  wire logic [5:0] set_post;
  wire logic [5:0] flag_set;
  wire logic [csr_width-1:0] csr_written;
  wire logic [csr_width-1:0] nxt_csr;
  assign csr_sel = reg_write && (reg_addr == csr_offset);
  assign sys_sel = reg_write && (reg_addr == sys_ctrl_offset);
  assign set_pre = in_pre ? pre_hit : 6'h00;
  assign set_post = in_post ? post_hit : 6'h00;
  assign flag_set = set_pre | set_post;
  assign csr_written = csr_sel ? (reg_wdata & csr_write_mask) : csr_ff;
  // set wins over a clearing write
  assign nxt_csr = csr_written | {26'h0, flag_set};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csr_ff <= csr_reset;
    end else begin
      csr_ff <= nxt_csr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_ctrl_ff <= sys_ctrl_reset;
    end else if (sys_sel) begin
      sys_ctrl_ff <= reg_wdata;
    end
  end

  wire logic [csr_width-1:0] rd_mux;
  assign rd_mux = (reg_addr == csr_offset) ? csr_ff :
    (reg_addr == sys_ctrl_offset) ? sys_ctrl_ff :
    (reg_addr == status_offset) ? {29'h0, state_ff} : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************
  // assertions
  // ****************
  a_pre_trap_seq: assert property (@(posedge clk) disable iff (rst)
    (in_pre && pre_unmasked) |=> (state_ff == st_pre_trap) && !compute_go)
    else $error("pre trap did not hold operands");
  a_trap_select: assert property (@(posedge clk) disable iff (rst)
    trap_fire |-> (simd_fp_trap == os_support) && (invalid_opcode_trap != os_support))
    else $error("wrong trap kind");
  a_resume_post: assert property (@(posedge clk) disable iff (rst)
    (state_ff == st_pre_trap && handler_return) |=> in_post)
    else $error("handler return did not resume post phase");
  a_post_trap_seq: assert property (@(posedge clk) disable iff (rst)
    (in_post && post_unmasked) |=> (state_ff == st_post_trap) && !result_write)
    else $error("post trap wrote results");
  a_masked_no_trap: assert property (@(posedge clk) disable iff (rst)
    (in_pre && !pre_unmasked) ##1 (in_post && !post_unmasked) |=> result_write ##1 !instr_busy)
    else $error("masked instruction did not complete");
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    ($past(csr_ff[invalid_flag_bit]) && !$past(csr_sel)) |-> csr_ff[invalid_flag_bit])
    else $error("sticky flag dropped");
  a_flag_or: assert property (@(posedge clk) disable iff (rst)
    (in_post && any_overflow) |=> csr_ff[overflow_flag_bit])
    else $error("overflow flag not set");
  a_ftz_inexact: assert property (@(posedge clk) disable iff (rst)
    (|flush_lane && in_post) |=> csr_ff[inexact_flag_bit])
    else $error("flush without inexact flag");
  a_no_write_trap: assert property (@(posedge clk) disable iff (rst)
    (state_ff == st_post_trap) |-> !result_write)
    else $error("masked results written early");
  a_invalid_flag_set: assert property (@(posedge clk) disable iff (rst)
    (in_pre && any_invalid) |=> csr_ff[invalid_flag_bit])
    else $error("invalid flag not set");
  a_denormal_flag_set: assert property (@(posedge clk) disable iff (rst)
    (in_pre && any_denormal) |=> csr_ff[denormal_flag_bit])
    else $error("denormal flag not set");
  a_divzero_flag_set: assert property (@(posedge clk) disable iff (rst)
    (in_pre && any_divzero) |=> csr_ff[divzero_flag_bit])
    else $error("divide by zero flag not set");
  a_underflow_flag_set: assert property (@(posedge clk) disable iff (rst)
    (in_post && any_underflow) |=> csr_ff[underflow_flag_bit])
    else $error("underflow flag not set");
  a_inexact_flag_set: assert property (@(posedge clk) disable iff (rst)
    (in_post && any_inexact) |=> csr_ff[inexact_flag_bit])
    else $error("inexact flag not set");
  a_pre_no_compute: assert property (@(posedge clk) disable iff (rst)
    in_pre |-> !compute_go && !result_write)
    else $error("compute during pre phase");
  a_pre_trap_hold: assert property (@(posedge clk) disable iff (rst)
    (state_ff == st_pre_trap && !handler_return) |=> (state_ff == st_pre_trap))
    else $error("pre trap left without handler return");
  a_post_trap_hold: assert property (@(posedge clk) disable iff (rst)
    (state_ff == st_post_trap && !handler_return) |=> (state_ff == st_post_trap))
    else $error("post trap left without handler return");
  a_trap_one_pulse: assert property (@(posedge clk) disable iff (rst)
    trap_fire |=> !simd_fp_trap && !invalid_opcode_trap)
    else $error("trap longer than one cycle");
  a_done_one_pulse: assert property (@(posedge clk) disable iff (rst)
    result_write |=> !result_write && !instr_busy)
    else $error("completion not a single pulse");
  a_post_after_pre: assert property (@(posedge clk) disable iff (rst)
    in_post |-> ($past(state_ff) == st_pre) || ($past(state_ff) == st_pre_trap))
    else $error("post phase without pre phase");
  a_csr_readback: assert property (@(posedge clk) disable iff (rst)
    (reg_read && reg_addr == csr_offset) |=> (reg_rdata == $past(csr_ff)))
    else $error("control status readback wrong");
  c_double_trap: cover property (@(posedge clk) disable iff (rst)
    (state_ff == st_pre_trap) ##[1:50] (state_ff == st_post_trap));
  c_masked_done: cover property (@(posedge clk) disable iff (rst)
    in_pre ##1 in_post ##1 result_write);
  c_opcode_trap: cover property (@(posedge clk) disable iff (rst) invalid_opcode_trap);
  c_post_only_trap: cover property (@(posedge clk) disable iff (rst)
    (in_pre && !pre_unmasked) ##1 (in_post && post_unmasked));
  c_daz_flush: cover property (@(posedge clk) disable iff (rst)
    (in_post && |daz_zero_lane && |flush_lane));
endmodule
`default_nettype wire

// file: tb/fpx_handler_model.sv
// partner model: trap handler that returns after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module fpx_handler_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // trap dispatch
  input wire logic simd_fp_trap,
  input wire logic invalid_opcode_trap,
  input wire logic [2:0] delay,
  output logic handler_return
);
  logic pend_ff;
  logic [2:0] cnt_ff;
  // ****************************************
  // handler: either trap kind, prompt or slow
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_ff <= 1'b0;
      cnt_ff <= 3'h0;
      handler_return <= 1'b0;
    end else begin
      handler_return <= 1'b0;
      if (simd_fp_trap | invalid_opcode_trap) begin
        pend_ff <= 1'b1;
        cnt_ff <= delay;
      end else if (pend_ff) begin
        if (cnt_ff == 3'h0) begin
          handler_return <= 1'b1;
          pend_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/simd_fp_exception_unit_tb_top.sv
// testbench: random instructions against a behavioural flag and trap model
`timescale 1ns/1ps
`default_nettype none
module simd_fp_exception_unit_tb_top;
  import fpx_pkg::*;
  localparam int lanes = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [addr_width-1:0] reg_addr = 4'h0;
  logic [csr_width-1:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_write = 1'b0, reg_read = 1'b0, instr_valid = 1'b0;
  op_class_type op_class = op_arith;
  logic [lanes-1:0] src_snan = '0, src_qnan = '0, src_denormal = '0, invalid_arith = '0;
  logic [lanes-1:0] dividend_finite_nonzero = '0, divisor_zero = '0;
  logic [lanes-1:0] res_too_big = '0, res_tiny = '0, res_inexact = '0;
  logic [lanes-1:0] daz_zero_lane, flush_lane, masked_default_lane;
  logic instr_busy, compute_go, result_write, instr_done;
  logic simd_fp_trap, invalid_opcode_trap, trap_post_phase, handler_return;
  logic [2:0] ret_delay = 3'h0;
  int fail_count = 0, checked = 0, cycles = 0, seed = 39;
  logic [csr_width-1:0] cfg, exp_flags;
  logic os_bit;
  int exp_q[$];

  always #25 clk = ~clk;

  simd_fp_exception_unit #(.lanes(lanes)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .instr_valid(instr_valid), .op_class(op_class), .src_snan(src_snan), .src_qnan(src_qnan),
    .src_denormal(src_denormal), .invalid_arith(invalid_arith),
    .dividend_finite_nonzero(dividend_finite_nonzero), .divisor_zero(divisor_zero),
    .res_too_big(res_too_big), .res_tiny(res_tiny), .res_inexact(res_inexact),
    .instr_busy(instr_busy), .daz_zero_lane(daz_zero_lane), .compute_go(compute_go),
    .flush_lane(flush_lane), .masked_default_lane(masked_default_lane),
    .result_write(result_write), .instr_done(instr_done), .simd_fp_trap(simd_fp_trap),
    .invalid_opcode_trap(invalid_opcode_trap), .trap_post_phase(trap_post_phase),
    .handler_return(handler_return));

  fpx_handler_model i_handler (.clk(clk), .rst(rst), .simd_fp_trap(simd_fp_trap),
    .invalid_opcode_trap(invalid_opcode_trap), .delay(ret_delay),
    .handler_return(handler_return));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  task automatic write_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic read_check(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check("reg_rdata", exp, reg_rdata);
  endtask

  // ****************************************
  // one instruction with model prediction
  // ****************************************
  task automatic run_instr();
    logic inv, den, dz, ov, uf, ix, noden, res_ok, done;
    logic [lanes-1:0] inv_l;
    logic [csr_width-1:0] m;
    op_class_type oc;
    int guard, go_n;
    @(posedge clk);
    oc = op_class_type'(4'($unsigned($random(seed)) % 7));
    res_ok = (oc == op_arith) || (oc == op_divide_double);
    op_class <= oc;
    src_snan <= lanes'($random(seed) & $random(seed));
    src_qnan <= lanes'($random(seed));
    src_denormal <= lanes'($random(seed));
    invalid_arith <= lanes'($random(seed) & $random(seed));
    dividend_finite_nonzero <= lanes'($random(seed));
    divisor_zero <= lanes'($random(seed));
    ret_delay <= 3'($random(seed));
    res_too_big <= res_ok ? lanes'($random(seed) & $random(seed)) : '0;
    res_tiny <= res_ok ? lanes'($random(seed)) : '0;
    res_inexact <= res_ok ? lanes'($random(seed)) : '0;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    m = cfg;
    noden = (op_class == op_convert_int) || (op_class == op_recip_approx);
    inv_l = src_snan | invalid_arith | ((op_class == op_ordered_compare ||
      op_class == op_compare_signaling) ? src_qnan : '0);
    inv = |inv_l;
    den = |src_denormal & !noden & !m[daz_bit];
    dz = (op_class == op_divide_double) && |(dividend_finite_nonzero & divisor_zero);
    ov = |res_too_big;
    uf = |(res_tiny & ((!m[underflow_mask_bit] || m[ftz_bit]) ? '1 : res_inexact));
    ix = |(res_inexact | ((m[underflow_mask_bit] && m[ftz_bit]) ? res_tiny : '0));
    exp_flags = exp_flags | csr_width'({ix, uf, ov, dz, den, inv});
    if (|({inv, den, dz} & ~{m[invalid_mask_bit], m[denormal_mask_bit], m[divzero_mask_bit]}))
      exp_q.push_back(0);
    if (|({ov, uf, ix} & ~{m[overflow_mask_bit], m[underflow_mask_bit], m[inexact_mask_bit]}))
      exp_q.push_back(1);
    done = 1'b0;
    go_n = 0;
    for (guard = 0; guard < 40 && !done; guard++) begin
      if ((simd_fp_trap | invalid_opcode_trap) === 1'b1) begin
        check("simd_fp_trap", 32'(os_bit), 32'(simd_fp_trap));
        check("invalid_opcode_trap", 32'(!os_bit), 32'(invalid_opcode_trap));
        if (exp_q.size() == 0) begin
          check("unexpected trap", 32'h0, 32'h1);
        end else begin
          check("trap_post_phase", 32'(exp_q.pop_front()), 32'(trap_post_phase));
        end
      end
      if (compute_go === 1'b1 && !noden) begin
        check("daz_zero_lane", 32'(m[daz_bit] ? src_denormal : '0), 32'(daz_zero_lane));
        check("flush_lane", 32'((m[ftz_bit] && m[underflow_mask_bit]) ? res_tiny : '0),
          32'(flush_lane));
      end
      check("result_write", 32'(instr_done), 32'(result_write));
      if (compute_go === 1'b1) begin
        go_n++;
      end
      if (result_write === 1'b1) begin
        check("masked_default_lane", 32'(m[invalid_mask_bit] ? inv_l : '0),
          32'(masked_default_lane));
        check("traps before write", 32'h0, 32'(exp_q.size()));
      end
      done = (instr_done === 1'b1);
      @(posedge clk);
      #1;
    end
    check("instr_done", 32'h1, 32'(done));
    check("pending traps", 32'h0, 32'(exp_q.size()));
    check("instr_busy", 32'h0, 32'(instr_busy));
    check("compute_go cycles", 32'h1, 32'(go_n));
    exp_q.delete();
    read_check(csr_offset, cfg | exp_flags);
    read_check(status_offset, 32'(st_idle));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    read_check(csr_offset, csr_reset);
    read_check(sys_ctrl_offset, sys_ctrl_reset);
    write_reg(4'hc, 32'hffff_ffff);
    read_check(4'hc, 32'h0000_0000);
    write_reg(csr_offset, 32'hffff_ffff);
    read_check(csr_offset, csr_write_mask);
    write_reg(csr_offset, csr_reset);
    read_check(csr_offset, csr_reset);
    for (int i = 0; i < 150; i++) begin
      if (i % 3 == 0) begin
        cfg = 32'($random(seed)) & 32'h0000_9fc0;
        exp_flags = 32'h0;
        os_bit = 1'($random(seed));
        write_reg(csr_offset, cfg);
        write_reg(sys_ctrl_offset, 32'(os_bit) << os_simd_trap_support_bit);
      end
      run_instr();
    end
    stop_test();
  end
endmodule
`default_nettype wire
